// [dv/host_burst_clock.sv]
`timescale 1ns/1ps
module host_burst_clock (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic run_i,
  output logic      burst_clk_o
);
  // ====
  // Burst clock, eight system clocks a period, still outside frames
  typedef struct packed {
    logic [2:0] ph;
    logic       bclk;
  } gen_t;
  gen_t st_r;
  gen_t st_nxt;
  always_comb begin
    st_nxt = st_r;
    st_nxt.ph = run_i ? st_r.ph + 3'h1 : 3'h0;
    st_nxt.bclk = run_i & st_nxt.ph[2];
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) st_r <= '0;
    else st_r <= st_nxt;
  end
  assign burst_clk_o = st_r.bclk;
endmodule

// [dv/psram_access_properties.sv]
`timescale 1ns/1ps
module psram_access_checker #(
  parameter int ADDR_W = 22
) (
  input wire logic              clk_i,
  input wire logic              reset_n_i,
  input wire logic              chip_select_n_i,
  input wire logic              output_enable_n_i,
  input wire logic              write_enable_n_i,
  input wire logic              upper_byte_enable_n_i,
  input wire logic              lower_byte_enable_n_i,
  input wire logic              mode_program_pin_n_i,
  input wire logic              address_latch_strobe_n_i,
  input wire logic              burst_clk_i,
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic [15:0]       dq_i,
  input wire logic [15:0]       dq_o,
  input wire logic [1:0]        dq_oe_n_o,
  input wire logic              wait_o,
  input wire logic              wait_oe_n_o
);
  // ====
  // Shadow of mode and polarity, ahead of the device by its sync lag
  typedef struct packed {
    logic sync;
    logic wp;
  } shadow_t;
  shadow_t cfg_r;
  shadow_t cfg_nxt;
  logic    prog;
  logic    rd_pins;
  assign prog = !mode_program_pin_n_i && !chip_select_n_i && !write_enable_n_i && output_enable_n_i;
  assign rd_pins = !chip_select_n_i && !output_enable_n_i && write_enable_n_i && mode_program_pin_n_i
                   && !(upper_byte_enable_n_i && lower_byte_enable_n_i) && !cfg_r.sync;
  always_comb begin
    cfg_nxt = cfg_r;
    if (prog) begin
      cfg_nxt.sync = address_i[15:14] == psram_pkg::MODE_SYNC;
      cfg_nxt.wp = address_i[13];
    end
  end
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) cfg_r <= '0;
    else cfg_r <= cfg_nxt;
  end
  // ====
  // Properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence rd_held;
    (rd_pins && $stable({upper_byte_enable_n_i, lower_byte_enable_n_i, address_i})) [*6];
  endsequence
  sequence data_start;
    cfg_r.sync && dq_oe_n_o != 2'h3 && $past(dq_oe_n_o) == 2'h3;
  endsequence
  a_idle_release: assert property (chip_select_n_i [*5] |-> dq_oe_n_o == 2'h3 && wait_oe_n_o)
    else $error("outputs driven while deselected");
  a_write_no_drive: assert property (
    (!chip_select_n_i && !write_enable_n_i && output_enable_n_i) [*5] |-> dq_oe_n_o == 2'h3)
    else $error("data driven during write");
  a_async_read_lanes: assert property (rd_held |-> dq_oe_n_o == {upper_byte_enable_n_i, lower_byte_enable_n_i})
    else $error("read lanes wrong");
  a_async_wait_off: assert property (!cfg_r.sync && !$past(cfg_r.sync, 4) |-> wait_oe_n_o)
    else $error("wait driven in async mode");
  a_data_has_wait: assert property (cfg_r.sync && dq_oe_n_o != 2'h3 |-> !wait_oe_n_o && wait_o == cfg_r.wp)
    else $error("wait not active with data");
  a_wait_leads_data: assert property (data_start |-> !$past(wait_oe_n_o, 4) && $past(wait_o, 4) == cfg_r.wp)
    else $error("wait not active one clock early");
  a_wait_starts_idle: assert property (cfg_r.sync && $fell(wait_oe_n_o) |-> wait_o == !cfg_r.wp)
    else $error("wait starts active");
  a_word_per_clock: assert property (
    cfg_r.sync && $changed(dq_o) && dq_oe_n_o != 2'h3 && $past(dq_oe_n_o) != 2'h3
    |=> ($stable(dq_o) || dq_oe_n_o == 2'h3) [*6])
    else $error("word changed between burst clocks");
endmodule
bind psram_access psram_access_checker #(.ADDR_W(ADDR_W)) checker_i (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .chip_select_n_i(chip_select_n_i),
  .output_enable_n_i(output_enable_n_i), .write_enable_n_i(write_enable_n_i),
  .upper_byte_enable_n_i(upper_byte_enable_n_i), .lower_byte_enable_n_i(lower_byte_enable_n_i),
  .mode_program_pin_n_i(mode_program_pin_n_i), .address_latch_strobe_n_i(address_latch_strobe_n_i),
  .burst_clk_i(burst_clk_i), .address_i(address_i), .dq_i(dq_i), .dq_o(dq_o),
  .dq_oe_n_o(dq_oe_n_o), .wait_o(wait_o), .wait_oe_n_o(wait_oe_n_o));

// [dv/psram_async_and_burst_access_bench.sv]
`timescale 1ns/1ps
module psram_async_and_burst_access_bench;
  localparam int L = 3;
  logic        clk_i = 1'h0, reset_n_i = 1'h0, run = 1'h0, bclk, wt, woe;
  logic        cs_n = 1'h1, oe_n = 1'h1, we_n = 1'h1, ub_n = 1'h1, lb_n = 1'h1, mp_n = 1'h1, adv_n = 1'h1;
  logic [21:0] addr = '0;
  logic [15:0] din = '0, dout;
  logic [1:0]  doe;
  int          n_mismatch = 0, samples_checked = 0, cyc = 0;
  psram_access dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .chip_select_n_i(cs_n), .output_enable_n_i(oe_n),
    .write_enable_n_i(we_n), .upper_byte_enable_n_i(ub_n), .lower_byte_enable_n_i(lb_n),
    .mode_program_pin_n_i(mp_n), .address_latch_strobe_n_i(adv_n), .burst_clk_i(bclk), .address_i(addr),
    .dq_i(din), .dq_o(dout), .dq_oe_n_o(doe), .wait_o(wt), .wait_oe_n_o(woe));
  host_burst_clock host (.clk_i(clk_i), .reset_n_i(reset_n_i), .run_i(run), .burst_clk_o(bclk));
  always #50 clk_i = ~clk_i;
  // ====
  // Shared tasks
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
    samples_checked++;
    if (got !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, got);
    end
  endtask
  task automatic pins(input logic [6:0] v, input logic [21:0] a, input logic [15:0] d);
    @(posedge clk_i);
    {cs_n, oe_n, we_n, ub_n, lb_n, mp_n, adv_n} <= v;
    addr <= a;
    din <= d;
  endtask
  task automatic idle(input int n);
    pins(7'h7f, addr, din);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic awrite(input logic [21:0] a, input logic [15:0] d, input logic [1:0] be, input logic mp);
    pins({3'h2, be, mp, 1'h0}, a, d);
    repeat (5) @(posedge clk_i);
    idle(4);
  endtask
  task automatic aread(input logic [21:0] a, input logic [1:0] be, input logic [15:0] e);
    logic [15:0] m;
    m = {{8{~be[1]}}, {8{~be[0]}}};
    pins({3'h1, be, 2'h3}, a, din);
    repeat (6) @(posedge clk_i);
    @(negedge clk_i);
    chk("read lanes", {14'h0, be}, {14'h0, doe});
    chk("read data", e & m, dout & m);
    chk("wait drive", 16'h1, {15'h0, woe});
  endtask
  // Reads keep the strobe low over two rises; writes latch by a strobe pulse
  task automatic burst(input logic wr, input logic wp, input logic [21:0] a, input int n, input logic stop,
                       input logic [15:0] w[4]);
    int f;
    f = 0;
    pins({1'h0, wr, ~wr, 4'h2}, a, din);
    if (wr) begin
      repeat (2) @(posedge clk_i);
      adv_n <= 1'h1;
      repeat (3) @(posedge clk_i);
      addr <= 22'h3ff;
    end
    @(posedge clk_i);
    run <= 1'h1;
    for (int t = 1; t <= 8 * (L + n) + 8; t++) begin
      @(posedge clk_i);
      if (t == 14) adv_n <= 1'h1;
      if (wr && t % 8 == 0 && t / 8 >= L && t / 8 < L + n) din <= w[t / 8 - L];
      if ((stop && f > 0 && t - f == 8 * n - 2) || (wr && t == 8 * (L + n) + 2)) cs_n <= 1'h1;
      if (t == 8 * (L + n) + 6) run <= 1'h0;
      @(negedge clk_i);
      if (!wr && f == 0 && doe === 2'h0) begin
        f = t;
        chk("first word delay", 16'h1, {15'h0, t inside {[8 * L + 5 : 8 * L + 10]}});
        chk("wait level", {14'h0, 1'h0, wp}, {14'h0, woe, wt});
      end
      if (f > 0 && (t - f) % 8 == 4 && (t - f) / 8 < n) chk("burst word", w[(t - f) / 8], dout);
    end
    idle(6);
    @(negedge clk_i);
    chk("data started", 16'h1, {15'h0, wr || f > 0});
    chk("burst release", 16'h7, {13'h0, doe, woe});
  endtask
  // ====
  // Scenarios
  task automatic t_async;
    for (int i = 0; i < 4; i++) awrite(22'h4 + 22'(i), 16'h1000 + 16'(i), 2'h0, 1'h1);
    awrite(22'h5, 16'hab77, 2'h1, 1'h1);
    run <= 1'h1;
    aread(22'h5, 2'h0, 16'hab01);
    aread(22'h6, 2'h0, 16'h1002);
    aread(22'h7, 2'h2, 16'h1003);
    @(posedge clk_i);
    run <= 1'h0;
    idle(4);
    $display("test async done");
  endtask
  task automatic t_burst_linear;
    awrite(22'h20, 16'h0, 2'h0, 1'h1);
    awrite(22'ha640, 16'h0, 2'h0, 1'h0);
    burst(1'h1, 1'h1, 22'ha, 4, 1'h0, '{16'hc0, 16'hc1, 16'hc2, 16'hc3});
    burst(1'h0, 1'h1, 22'h8, 4, 1'h0, '{16'hc2, 16'hc3, 16'hc0, 16'hc1});
    $display("test burst linear done");
  endtask
  task automatic t_burst_interleave;
    awrite(22'h8740, 16'h0, 2'h0, 1'h0);
    burst(1'h0, 1'h0, 22'h5, 2, 1'h1, '{16'hab01, 16'h1000, 16'h0, 16'h0});
    $display("test burst interleave done");
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'h1;
    @(posedge clk_i);
    t_async();
    t_burst_linear();
    t_burst_interleave();
    tally_and_finish();
  end
endmodule

// [inc/psram_pkg.sv]
// Contract
// - Async read starts when chip select, output enable and a byte enable are low.
// - Changing only address bits 1:0 gives later words after the shorter page time.
// - Async reads ignore burst clock and latch strobe; wait output stays released.
// - Async write starts when chip select, write enable and a byte enable are low.
// - Async write in sync mode ignores burst clock; strobe may latch or stay low. Code starts a burst write on a clock rise with strobe low or latched.
// - Burst address latched at first clock rise or strobe rise; host selects chip first.
// - At burst command edge, write enable high means read, low means write.
// - Burst read recognised at clock rise with strobe low and write enable high.
// - Further clock rises during the same low strobe do not restart the command.
// - First read word after latency clocks, then one word per clock.
// - Burst write recognised with strobe and write enable low; data taken at latency clock.
// - All burst transfers happen on rising edges of the burst clock.
// - Burst lengths 4, 8, 16 and 256 words for reads and writes.
// - Chip select high stops a running burst at once.
// - Wait indicator polarity is chosen by configuration.
// - Wait indicator turns active one clock before each burst's data.
// - Linear order increments and wraps within the aligned burst block.
// - Interleaved order is start XOR counter; 256 words use linear only.
// - Configuration takes burst length from bits 7:5 and burst type from bit 8.
// - Latency from bits 11:9, wait polarity bit 13, operation mode bits 15:14.
package psram_pkg;

  // ==========================================================
  // Configuration word layout
  localparam int          CFG_W     = 16;
  localparam int          BL_LSB    = 5;
  localparam int          BT_BIT    = 8;
  localparam int          LAT_LSB   = 9;
  localparam int          WP_BIT    = 13;
  localparam int          MODE_LSB  = 14;
  localparam logic [1:0]  MODE_SYNC = 2'h2;
  localparam logic [2:0]  BL_CODE_4   = 3'h2;
  localparam logic [2:0]  BL_CODE_8   = 3'h3;
  localparam logic [2:0]  BL_CODE_16  = 3'h4;
  localparam logic [2:0]  BL_CODE_256 = 3'h7;
  localparam logic [3:0]  BL_LOG2_DEF = 4'h2;
  localparam logic [2:0]  LAT_MIN   = 3'h2;
  localparam logic [2:0]  LAT_DEF   = 3'h4;
  localparam logic [15:0] CFG_RST   = 16'h0000;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS       = 100;
  localparam int READ_CYCLE_TIME_NS  = 70;
  localparam int PAGE_CYCLE_TIME_NS  = 25;
  localparam int BURST_CYCLE_TIME_NS = 2500;
  localparam int RC_RAW = (READ_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PC_RAW = (PAGE_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RC_CYC = (RC_RAW < 1) ? 1 : RC_RAW;
  localparam int PC_CYC = (PC_RAW < 1) ? 1 : PC_RAW;

  // ==========================================================
  // Access phases
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_AREAD = 2'b01,
    PH_BURST = 2'b10
  } phase_t;

endpackage

// [logic/pin_sync.sv]
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sync_st_t;

  sync_st_t st_r;
  sync_st_t st_nxt;

  // ==========================================================
  // Two stages; only the second stage is read outside
  always_comb begin
    st_nxt      = st_r;
    st_nxt.meta = d_i;
    st_nxt.q    = st_r.meta;
  end

  // Idle-high reset keeps active-low pins inactive
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.q;

endmodule

// [logic/psram_access.sv]
`timescale 1ns/1ps
module psram_access #(
  parameter int ADDR_W = 22,
  parameter int MEM_AW = 10
) (
  input  wire logic              clk_i,
  input  wire logic              reset_n_i,
  input  wire logic              chip_select_n_i,
  input  wire logic              output_enable_n_i,
  input  wire logic              write_enable_n_i,
  input  wire logic              upper_byte_enable_n_i,
  input  wire logic              lower_byte_enable_n_i,
  input  wire logic              mode_program_pin_n_i,
  input  wire logic              address_latch_strobe_n_i,
  input  wire logic              burst_clk_i,
  input  wire logic [ADDR_W-1:0] address_i,
  input  wire logic [15:0]       dq_i,
  output logic      [15:0]       dq_o,
  output logic      [1:0]        dq_oe_n_o,
  output logic                   wait_o,
  output logic                   wait_oe_n_o
);

  localparam int DEPTH = 1 << MEM_AW;
  localparam int SW    = 8 + ADDR_W + 16;

  // ==========================================================
  // Elaboration checks
  if (ADDR_W < psram_pkg::CFG_W) begin : g_chk_addr
    $error("ADDR_W must cover the configuration word");
  end
  if (MEM_AW <= 8 || MEM_AW > ADDR_W) begin : g_chk_mem
    $error("MEM_AW must exceed 8 and fit ADDR_W");
  end

  typedef struct packed {
    psram_pkg::phase_t            phase;
    logic [3:0]                   tmr;
    logic [ADDR_W-1:0]            raddr;
    logic [ADDR_W-1:0]            lat_addr;
    logic                         lat_valid;
    logic [ADDR_W-1:0]            start;
    logic                         bwrite;
    logic [3:0]                   cnt;
    logic [8:0]                   idx;
    logic [15:0]                  cfg;
    logic                         bclk_q;
    logic                         adv_q;
    logic [15:0]                  dq;
    logic [1:0]                   dq_oe_n;
    logic                         wt;
    logic                         wt_oe_n;
    logic [DEPTH-1:0][15:0]       mem;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  // ==========================================================
  // Pin synchronisers
  logic [SW-1:0]     sync_q;
  logic              s_cs_n;
  logic              s_oe_n;
  logic              s_we_n;
  logic              s_ub_n;
  logic              s_lb_n;
  logic              s_mrs_n;
  logic              s_adv_n;
  logic              s_bclk;
  logic [ADDR_W-1:0] s_addr;
  logic [15:0]       s_dq;

  pin_sync #(
    .W (SW)
  ) u_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       ({chip_select_n_i, output_enable_n_i, write_enable_n_i,
                 upper_byte_enable_n_i, lower_byte_enable_n_i,
                 mode_program_pin_n_i, address_latch_strobe_n_i,
                 burst_clk_i, address_i, dq_i}),
    .q_o       (sync_q)
  );

  assign {s_cs_n, s_oe_n, s_we_n, s_ub_n, s_lb_n, s_mrs_n, s_adv_n,
          s_bclk, s_addr, s_dq} = sync_q;

  // ==========================================================
  // Configuration decode
  function automatic logic [3:0] bl_log2(input logic [15:0] c);
    logic [2:0] code;
    code = c[psram_pkg::BL_LSB +: 3];
    if (code == psram_pkg::BL_CODE_4) begin
      bl_log2 = 4'h2;
    end else if (code == psram_pkg::BL_CODE_8) begin
      bl_log2 = 4'h3;
    end else if (code == psram_pkg::BL_CODE_16) begin
      bl_log2 = 4'h4;
    end else if (code == psram_pkg::BL_CODE_256) begin
      bl_log2 = 4'h8;
    end else begin
      bl_log2 = psram_pkg::BL_LOG2_DEF; // Reserved code falls back
    end
  endfunction

  function automatic logic [2:0] lat_count(input logic [15:0] c);
    logic [2:0] code;
    code = c[psram_pkg::LAT_LSB +: 3];
    if (code < psram_pkg::LAT_MIN) begin
      lat_count = psram_pkg::LAT_DEF;
    end else begin
      lat_count = code;
    end
  endfunction

  // Word address of beat i within the burst block
  function automatic logic [MEM_AW-1:0] burst_addr(
    input logic [ADDR_W-1:0] s,
    input logic [8:0]        i,
    input logic [3:0]        lg,
    input logic              ilv
  );
    logic [8:0] len;
    logic [7:0] mask;
    logic [7:0] off;
    len  = 9'h1 << lg;
    mask = 8'(len - 9'h1);
    if (ilv && lg != 4'h8) begin
      off = (s[7:0] ^ i[7:0]) & mask;
    end else begin
      off = 8'(s[7:0] + i[7:0]) & mask;
    end
    burst_addr = {s[MEM_AW-1:8], (s[7:0] & ~mask) | off};
  endfunction

  function automatic logic [15:0] merge(
    input logic [15:0] old_w,
    input logic [15:0] new_w,
    input logic        ub_n,
    input logic        lb_n
  );
    merge = old_w;
    if (!ub_n) begin
      merge[15:8] = new_w[15:8];
    end
    if (!lb_n) begin
      merge[7:0] = new_w[7:0];
    end
  endfunction

  // ==========================================================
  // Next-state logic
  logic              bclk_rise;
  logic              adv_rise;
  logic              sync_mode;
  logic              wp;
  logic              be_any;
  logic              rd_req;
  logic              wr_req;
  logic [ADDR_W-1:0] eff_addr;
  logic [2:0]        lat;
  logic [3:0]        lg;
  logic [8:0]        len;
  logic [3:0]        cnt_nx;
  logic [MEM_AW-1:0] ba;

  always_comb begin
    st_nxt    = st_r;
    bclk_rise = s_bclk & ~st_r.bclk_q;
    adv_rise  = s_adv_n & ~st_r.adv_q;
    sync_mode = st_r.cfg[psram_pkg::MODE_LSB +: 2] == psram_pkg::MODE_SYNC;
    wp        = st_r.cfg[psram_pkg::WP_BIT];
    lat       = lat_count(st_r.cfg);
    lg        = bl_log2(st_r.cfg);
    len       = 9'h1 << lg;
    be_any    = ~(s_ub_n & s_lb_n);
    rd_req    = ~s_cs_n & ~s_oe_n & s_we_n & be_any;
    wr_req    = ~s_cs_n & ~s_we_n & be_any & s_oe_n;
    cnt_nx    = (st_r.cnt == 4'hf) ? st_r.cnt : st_r.cnt + 4'h1;
    ba        = burst_addr(st_r.start, st_r.idx, lg, st_r.cfg[psram_pkg::BT_BIT]);
    eff_addr  = (s_adv_n && st_r.lat_valid) ? st_r.lat_addr : s_addr;

    st_nxt.bclk_q = s_bclk;
    st_nxt.adv_q  = s_adv_n;

    // Strobe rise may latch the address before any clock edge
    if (s_cs_n) begin
      st_nxt.lat_valid = 1'b0;
    end else if (adv_rise) begin
      st_nxt.lat_addr  = s_addr;
      st_nxt.lat_valid = 1'b1;
    end

    case (st_r.phase)
      psram_pkg::PH_IDLE: begin
        st_nxt.dq_oe_n = 2'b11;
        st_nxt.wt_oe_n = 1'b1;
        if (sync_mode && !s_cs_n && bclk_rise &&
            (!s_adv_n || st_r.lat_valid)) begin
          // Earlier strobe latch wins over the live address
          st_nxt.start     = st_r.lat_valid ? st_r.lat_addr : s_addr;
          st_nxt.bwrite    = ~s_we_n;
          st_nxt.cnt       = 4'h0;
          st_nxt.idx       = 9'h0;
          st_nxt.lat_valid = 1'b0;
          st_nxt.wt_oe_n   = 1'b0;
          st_nxt.wt        = ~wp;
          st_nxt.phase     = psram_pkg::PH_BURST;
        end else if (wr_req && !s_mrs_n) begin
          st_nxt.cfg = s_addr[psram_pkg::CFG_W-1:0];
        end else if (wr_req) begin
          // Burst clock plays no part here
          st_nxt.mem[eff_addr[MEM_AW-1:0]] =
            merge(st_r.mem[eff_addr[MEM_AW-1:0]], s_dq, s_ub_n, s_lb_n);
        end else if (rd_req && s_mrs_n && !sync_mode) begin
          st_nxt.tmr   = 4'(psram_pkg::RC_CYC - 1);
          st_nxt.raddr = s_addr;
          st_nxt.phase = psram_pkg::PH_AREAD;
        end
      end

      psram_pkg::PH_AREAD: begin
        // Burst clock and strobe are not looked at here
        st_nxt.wt_oe_n = 1'b1;
        if (!rd_req) begin
          st_nxt.dq_oe_n = 2'b11;
          st_nxt.phase   = psram_pkg::PH_IDLE;
        end else if (s_addr[ADDR_W-1:2] != st_r.raddr[ADDR_W-1:2]) begin
          st_nxt.tmr     = 4'(psram_pkg::RC_CYC - 1);
          st_nxt.raddr   = s_addr;
          st_nxt.dq_oe_n = 2'b11;
        end else if (s_addr[1:0] != st_r.raddr[1:0]) begin
          st_nxt.tmr     = 4'(psram_pkg::PC_CYC - 1);
          st_nxt.raddr   = s_addr;
          st_nxt.dq_oe_n = 2'b11;
        end else if (st_r.tmr != 4'h0) begin
          st_nxt.tmr = st_r.tmr - 4'h1;
        end else begin
          st_nxt.dq      = st_r.mem[st_r.raddr[MEM_AW-1:0]];
          st_nxt.dq_oe_n = {s_ub_n, s_lb_n};
        end
      end

      psram_pkg::PH_BURST: begin
        if (s_cs_n) begin
          // Deselect ends the burst without waiting for a clock
          st_nxt.dq_oe_n = 2'b11;
          st_nxt.wt_oe_n = 1'b1;
          st_nxt.phase   = psram_pkg::PH_IDLE;
        end else if (bclk_rise) begin
          if (st_r.idx == len) begin
            st_nxt.dq_oe_n = 2'b11;
            st_nxt.wt_oe_n = 1'b1;
            st_nxt.phase   = psram_pkg::PH_IDLE;
          end else begin
            // Later rises under a low strobe count latency, then move one word each
            st_nxt.cnt = cnt_nx;
            if (cnt_nx == 4'(lat) - 4'h1) begin
              st_nxt.wt = wp;
            end
            if (cnt_nx >= 4'(lat)) begin
              st_nxt.idx = st_r.idx + 9'h1;
              if (st_r.bwrite) begin
                st_nxt.mem[ba] = merge(st_r.mem[ba], s_dq, s_ub_n, s_lb_n);
              end else begin
                st_nxt.dq      = st_r.mem[ba];
                st_nxt.dq_oe_n = {s_ub_n, s_lb_n};
              end
            end
          end
        end
      end

      default: begin
        st_nxt.dq_oe_n = 2'b11;
        st_nxt.wt_oe_n = 1'b1;
        st_nxt.phase   = psram_pkg::PH_IDLE;
      end
    endcase

    // Level follows polarity bit; inactive means not-ready
    if (st_nxt.wt_oe_n) begin
      st_nxt.wt = ~wp;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      st_r         <= '0;
      st_r.cfg     <= psram_pkg::CFG_RST;
      st_r.dq_oe_n <= 2'b11;
      st_r.wt_oe_n <= 1'b1;
      st_r.wt      <= 1'b1;
      // Synchronisers reset high; matching avoids a false edge
      st_r.bclk_q  <= 1'b1;
      st_r.adv_q   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dq_o        = st_r.dq;
  assign dq_oe_n_o   = st_r.dq_oe_n;
  assign wait_o      = st_r.wt;
  assign wait_oe_n_o = st_r.wt_oe_n;

endmodule
